/* shared/debug_defs.vh */
// Purpose: constants for the on-chip debug breakpoint and trace block
// Assumes: APB register words at byte offsets, 8-bit paddr
// Notes:   fields sit in the low byte of each word, 16-bit ones in the low halfword
// Notes on behaviour
// [RULE1] simple breakpoint compares each CPU address with 16-bit match value
// [RULE2] forced simple break: background entry at next instruction boundary
// [RULE3] tagged simple break marks the fetched opcode at the match address
// [RULE4] simple breakpoint only while its enable is 1; enable resets to 0
// [RULE5] force_tag_select 1 chooses forced, 0 chooses tagged breakpoints
// [RULE6] eight-stage capture FIFO, trigger logic decides when and what
// [RULE7] two 16-bit comparators, each optionally qualified by read/write
// [RULE8] tag trigger mode routes each match through own opcode tracker
// [RULE9] comparators do greater/less-or-equal for inside and outside range
// [RULE10] comparators muted during every background controller access
// [RULE11] A compares address; B compares address or data byte by mode
// [RULE12] full modes: B uses write data if A qualified on write
// [RULE13] match may break CPU, store data, start or stop flow capture
// [RULE14] status shows valid count; early stop needs (8-count)-1 dummy reads
// [RULE15] read high port first; low port read shifts FIFO
// [RULE16] event modes store 8-bit data; low port read shifts
// [RULE17] flow address at or two bus cycles after begin trigger not stored
// [RULE18] end trace stores a flow-change trigger as last entry
// [RULE19] unarmed low port read pushes last fetched opcode address
// [RULE20] taken conditional branch stores own address; always/never none
// [RULE21] indirect jump/call, interrupt and returns store destination
// [RULE22] tag request travels with opcode; force waits for boundary
// [RULE23] writing arm 1 sets armed flag, clears match flags and count
`ifndef DEBUG_DEFS_VH
`define DEBUG_DEFS_VH
// register byte offsets
`define OFF_BDC_SC    8'h00
`define OFF_BDC_MATCH 8'h04
`define OFF_CMP_A     8'h08
`define OFF_CMP_B     8'h0c
`define OFF_DBG_CTRL  8'h10
`define OFF_DBG_TRIG  8'h14
`define OFF_DBG_STAT  8'h18
`define OFF_FIFO_HI   8'h1c
`define OFF_FIFO_LO   8'h20
// bdc_status_control bits
`define BIT_SB_EN     7
`define BIT_FTS       6
// control bits
`define BIT_ARM       7
`define BIT_BRKEN     6
`define BIT_TAG       5
`define BIT_CMP_A_RW_QUALIFY_ENABLE     3
`define BIT_RWA       2
`define BIT_RWBEN     1
`define BIT_RWB       0
// trigger register bits
`define BIT_TRIGGER_TAG_SELECT    7
`define BIT_BEGIN     6
// status bits
`define BIT_AF        7
`define BIT_BF        6
`define BIT_ARMED_FLAG      5
// trigger modes
`define MODE_A_ONLY   4'h0
`define MODE_A_OR_B   4'h1
`define MODE_A_THEN_B 4'h2
`define MODE_FULL_EQ  4'h3
`define MODE_FULL_NE  4'h4
`define MODE_EVT_B    4'h5
`define MODE_A_EVT_B  4'h6
`define MODE_INSIDE   4'h7
`define MODE_OUTSIDE  4'h8
// flow-change kinds from the CPU
`define COF_COND      2'h0
`define COF_ALWAYS    2'h1
`define COF_INDIRECT  2'h2
`define COF_RETURN    2'h3
// counts
`define FIFO_FULL     4'h8
`define BEGIN_SKIP    2'h2
`endif

/* verilog/opcode_tracker.v */
// Purpose: follows tagged opcodes through the instruction queue
// Assumes: one push per fetch, one pop per executed opcode
// Notes:   flush drops all queued tags, as the CPU drops the queue
`default_nettype none
module opcode_tracker #(
  parameter DEPTH = 4,
  parameter CW    = 3
) (
  input  wire       clk,
  input  wire       rst_n,
  input  wire       fetch,
  input  wire       hit,
  input  wire       exec,
  input  wire       flush,
  output wire       trig
);
  reg [DEPTH-1:0] tag_ff;
  reg [CW-1:0]    cnt_ff;
  reg [DEPTH-1:0] nxt_tag;
  reg [CW-1:0]    nxt_cnt;
  integer         i;

  // trigger only when the tagged opcode really executes
  assign trig = exec & (cnt_ff != {CW{1'b0}}) & tag_ff[0]; // RULE8

  // pop at head, push behind the last entry
  always @*
  begin
    nxt_tag = tag_ff;
    nxt_cnt = cnt_ff;
    if (exec && cnt_ff != {CW{1'b0}})
    begin
      nxt_tag = tag_ff >> 1;
      nxt_cnt = cnt_ff - 1'b1;
    end
    if (fetch && nxt_cnt < DEPTH)
    begin
      for (i = 0; i < DEPTH; i = i + 1)
        if (i == nxt_cnt)
          nxt_tag[i] = hit; // RULE8
      nxt_cnt = nxt_cnt + 1'b1;
    end
    if (flush)
      nxt_cnt = {CW{1'b0}};
  end

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tag_ff <= {DEPTH{1'b0}};
      cnt_ff <= {CW{1'b0}};
    end
    else
    begin
      tag_ff <= nxt_tag;
      cnt_ff <= nxt_cnt;
    end
  end
endmodule // opcode_tracker
`default_nettype wire

/* verilog/debug_unit.v */
// Purpose: simple breakpoint, two comparators, trigger and trace FIFO
// Assumes: CPU bus signals arrive on pclk, no synchronising needed
// Notes:   zero-wait APB slave, unmapped offsets answer pslverr
//
// Chosen here: register access over APB and the register offsets.
`include "debug_defs.vh"
`default_nettype none
module debug_unit #(
  parameter DEPTH = 8,
  parameter QDEP  = 4
) (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire        cpu_valid,
  input  wire        cpu_rw,
  input  wire        cpu_opfetch,
  input  wire [15:0] cpu_addr,
  input  wire [7:0]  cpu_rdata,
  input  wire [7:0]  cpu_wdata,
  input  wire        bdc_access,
  input  wire        q_exec,
  input  wire        q_flush,
  input  wire        insn_boundary,
  input  wire        cof_valid,
  input  wire [1:0]  cof_kind,
  input  wire        cof_taken,
  input  wire [15:0] cof_src,
  input  wire [15:0] cof_dst,
  output wire        tag_break_req,
  output wire        force_break_req
);
  reg  [7:0]  bdc_status_control_ff;
  reg  [15:0] bdc_match_address_ff;
  reg  [15:0] cmp_a_ff;
  reg  [15:0] cmp_b_ff;
  reg  [7:0]  ctrl_ff;
  reg  [7:0]  debug_trigger_reg_ff;
  reg         armed_ff;
  reg         af_ff;
  reg         bf_ff;
  reg  [3:0]  fifo_valid_count_ff;
  reg         seen_a_ff;
  reg         started_ff;
  reg  [1:0]  skip_ff;
  reg  [15:0] last_fetch_ff;
  reg         force_pend_ff;
  reg  [15:0] fifo_ff [0:DEPTH-1];
  reg         mapped;
  reg  [31:0] rd_mux;
  reg         trigger;
  reg         push;
  reg  [15:0] push_val;
  integer     i;

  // rw qualifier: ignored when its enable is clear
  function rw_ok;
    input en;
    input val;
    input rw;
    begin
      rw_ok = !en || (rw == val);
    end
  endfunction

  wire       wr_en  = psel & penable & pwrite;
  wire       rd_en  = psel & penable & !pwrite;
  wire [3:0] mode   = debug_trigger_reg_ff[3:0];
  wire       evt    = (mode == `MODE_EVT_B) || (mode == `MODE_A_EVT_B);
  wire       full   = (mode == `MODE_FULL_EQ) || (mode == `MODE_FULL_NE);
  wire       range  = (mode == `MODE_INSIDE) || (mode == `MODE_OUTSIDE);
  wire       cmp_a_rw_qualify_enable  = ctrl_ff[`BIT_CMP_A_RW_QUALIFY_ENABLE];
  wire       cmp_a_rw_value    = ctrl_ff[`BIT_RWA];
  wire       trigger_tag_select = debug_trigger_reg_ff[`BIT_TRIGGER_TAG_SELECT];
  wire       begin_t = debug_trigger_reg_ff[`BIT_BEGIN] | evt;
  wire       rd_lo  = rd_en && paddr == `OFF_FIFO_LO;
  wire       full_q = fifo_valid_count_ff == `FIFO_FULL;

  // debugger bus cycles never match comparators A and B
  wire bus_ok = cpu_valid & !bdc_access; // RULE10

  // data byte for B: write bus only for A qualified on write
  wire [7:0] dsel = (cmp_a_rw_qualify_enable && !cmp_a_rw_value) ? cpu_wdata : cpu_rdata; // RULE12

  // comparator A on address, B on address or data byte
  wire a_q = bus_ok & (cpu_addr == cmp_a_ff)
             & rw_ok(cmp_a_rw_qualify_enable, cmp_a_rw_value, cpu_rw); // RULE7 RULE11
  wire b_q = bus_ok & (cpu_addr == cmp_b_ff)
             & rw_ok(ctrl_ff[`BIT_RWBEN], ctrl_ff[`BIT_RWB], cpu_rw); // RULE7
  wire b_dat = dsel == cmp_b_ff[7:0]; // RULE11
  wire ge_a  = cpu_addr >= cmp_a_ff; // RULE9
  wire le_b  = cpu_addr <= cmp_b_ff; // RULE9
  wire a_rw  = bus_ok & rw_ok(cmp_a_rw_qualify_enable, cmp_a_rw_value, cpu_rw);

  // A-side condition folded with data or range checks
  reg cond_a;
  always @*
  begin
    case (mode)
      `MODE_FULL_EQ: cond_a = a_q & b_dat;
      `MODE_FULL_NE: cond_a = a_q & !b_dat;
      `MODE_INSIDE:  cond_a = a_rw & ge_a & le_b; // RULE9
      `MODE_OUTSIDE: cond_a = a_rw & !(ge_a & le_b); // RULE9
      default:       cond_a = a_q;
    endcase
  end

  // separate trackers so both channels can be in flight
  wire trk_a;
  wire trk_b;
  opcode_tracker #(.DEPTH(QDEP), .CW(3)) u_trk_a (
    .clk   (pclk),
    .rst_n (presetn),
    .fetch (cpu_valid & cpu_opfetch),
    .hit   (cond_a),
    .exec  (q_exec),
    .flush (q_flush),
    .trig  (trk_a)
  );
  opcode_tracker #(.DEPTH(QDEP), .CW(3)) u_trk_b (
    .clk   (pclk),
    .rst_n (presetn),
    .fetch (cpu_valid & cpu_opfetch),
    .hit   (b_q),
    .exec  (q_exec),
    .flush (q_flush),
    .trig  (trk_b)
  );
  wire ta = trigger_tag_select ? trk_a : cond_a; // RULE8
  wire tb = trigger_tag_select ? trk_b : b_q; // RULE8

  // trigger decode per mode
  always @*
  begin
    case (mode)
      `MODE_A_OR_B:  trigger = ta | tb;
      `MODE_A_THEN_B: trigger = tb & seen_a_ff;
      `MODE_EVT_B:   trigger = tb;
      `MODE_A_EVT_B: trigger = tb & seen_a_ff;
      default:       trigger = ta;
    endcase
    trigger = trigger & armed_ff;
  end

  // flow-change address; always/never branches store nothing
  reg        cof_hit;
  reg [15:0] cof_addr;
  always @*
  begin
    cof_addr = cof_dst; // RULE21
    case (cof_kind)
      `COF_COND:
      begin
        cof_hit  = cof_valid & cof_taken; // RULE20
        cof_addr = cof_src; // RULE20
      end
      `COF_ALWAYS: cof_hit = 1'b0; // RULE20
      default:     cof_hit = cof_valid; // RULE21
    endcase
  end

  // capture decision
  always @*
  begin
    push     = 1'b0;
    push_val = cof_addr;
    if (!armed_ff)
    begin
      push     = rd_lo; // RULE19
      push_val = last_fetch_ff; // RULE19
    end
    else if (evt)
    begin
      push     = trigger & !full_q; // RULE13 RULE16
      push_val = {8'h00, dsel}; // RULE16
    end
    else if (begin_t)
      // pipeline delay hides trigger cycle and two bus cycles after
      push = cof_hit & started_ff & (skip_ff == 2'h0) & !full_q; // RULE17
    else
      push = cof_hit; // RULE13 RULE18
  end

  // simple breakpoint, gated by its enable
  wire sb_en  = bdc_status_control_ff[`BIT_SB_EN];
  wire sb_fts = bdc_status_control_ff[`BIT_FTS];
  wire sb_hit = sb_en & cpu_valid
                & (cpu_addr == bdc_match_address_ff); // RULE1 RULE4
  wire brk    = ctrl_ff[`BIT_BRKEN];
  wire tagsel = ctrl_ff[`BIT_TAG];

  // tag goes out with the fetch so it rides the queue
  assign tag_break_req = cpu_valid & cpu_opfetch & (
    (sb_hit & !sb_fts) // RULE3 RULE5 RULE22
    | (brk & tagsel & (full ? a_q : (cond_a | b_q)))); // RULE13 RULE22
  assign force_break_req = force_pend_ff; // RULE22

  // read mux
  always @*
  begin
    mapped = 1'b1;
    rd_mux = 32'h0000_0000;
    case (paddr)
      `OFF_BDC_SC:    rd_mux[7:0] = bdc_status_control_ff;
      `OFF_BDC_MATCH: rd_mux[15:0] = bdc_match_address_ff;
      `OFF_CMP_A:     rd_mux[15:0] = cmp_a_ff;
      `OFF_CMP_B:     rd_mux[15:0] = cmp_b_ff;
      `OFF_DBG_CTRL:  rd_mux[7:0] = ctrl_ff;
      `OFF_DBG_TRIG:  rd_mux[7:0] = debug_trigger_reg_ff;
      `OFF_DBG_STAT:  rd_mux[7:0] = {af_ff, bf_ff, armed_ff, 1'b0,
                                     fifo_valid_count_ff}; // RULE14
      `OFF_FIFO_HI:   rd_mux[7:0] = fifo_ff[DEPTH-1][15:8]; // RULE15
      `OFF_FIFO_LO:   rd_mux[7:0] = fifo_ff[DEPTH-1][7:0]; // RULE15
      default:        mapped = 1'b0;
    endcase
  end

  assign pready  = 1'b1;
  assign pslverr = psel & penable & !mapped;

  // read data latched in setup so it comes from a flop
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (psel && !penable)
      prdata <= rd_mux;
  end

  // software registers
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      bdc_status_control_ff <= 8'h00; // RULE4
      bdc_match_address_ff  <= 16'h0000;
      cmp_a_ff              <= 16'h0000;
      cmp_b_ff              <= 16'h0000;
      ctrl_ff               <= 8'h00;
      debug_trigger_reg_ff  <= 8'h00;
    end
    else if (wr_en)
    begin
      case (paddr)
        `OFF_BDC_SC:    bdc_status_control_ff <= pwdata[7:0];
        `OFF_BDC_MATCH: bdc_match_address_ff <= pwdata[15:0];
        `OFF_CMP_A:     cmp_a_ff <= pwdata[15:0];
        `OFF_CMP_B:     cmp_b_ff <= pwdata[15:0];
        `OFF_DBG_CTRL:  ctrl_ff <= pwdata[7:0];
        `OFF_DBG_TRIG:  debug_trigger_reg_ff <= pwdata[7:0];
        default:        ctrl_ff <= ctrl_ff;
      endcase
    end
  end

  wire arm_wr = wr_en && paddr == `OFF_DBG_CTRL;
  // hand stop before full moves the data up one place
  wire stop_sh = arm_wr & !pwdata[`BIT_ARM] & armed_ff & !full_q; // RULE14

  // run control, flags and count
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      armed_ff            <= 1'b0;
      af_ff               <= 1'b0;
      bf_ff               <= 1'b0;
      fifo_valid_count_ff <= 4'h0;
      seen_a_ff           <= 1'b0;
      started_ff          <= 1'b0;
      skip_ff             <= 2'h0;
    end
    else if (arm_wr)
    begin
      armed_ff <= pwdata[`BIT_ARM]; // RULE23
      if (pwdata[`BIT_ARM])
      begin
        af_ff               <= 1'b0; // RULE23
        bf_ff               <= 1'b0; // RULE23
        fifo_valid_count_ff <= 4'h0; // RULE23
        seen_a_ff           <= 1'b0;
        started_ff          <= evt;
        skip_ff             <= 2'h0;
      end
    end
    else
    begin
      // match flags never set during any control write, so a hit in that cycle is lost
      if (armed_ff && ta)
      begin
        af_ff     <= 1'b1;
        seen_a_ff <= 1'b1;
      end
      if (armed_ff && tb)
        bf_ff <= 1'b1;
      if (push && !full_q)
        fifo_valid_count_ff <= fifo_valid_count_ff + 4'h1; // RULE14
      if (trigger && begin_t && !evt && !started_ff)
      begin
        started_ff <= 1'b1; // RULE13
        skip_ff    <= `BEGIN_SKIP; // RULE17
      end
      else if (cpu_valid && skip_ff != 2'h0)
        skip_ff <= skip_ff - 2'h1; // RULE17
      // end trace stops on trigger, begin trace when full
      if (trigger && !begin_t)
        armed_ff <= 1'b0; // RULE13 RULE18
      else if (armed_ff && begin_t && full_q)
        armed_ff <= 1'b0;
    end
  end

  // capture FIFO, oldest word at the read port
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (i = 0; i < DEPTH; i = i + 1)
        fifo_ff[i] <= 16'h0000;
    end
    else if (push || rd_lo || stop_sh)
    begin
      for (i = DEPTH - 1; i > 0; i = i - 1)
        fifo_ff[i] <= fifo_ff[i-1]; // RULE6 RULE15 RULE16
      fifo_ff[0] <= push ? push_val : 16'h0000;
    end
  end

  // last opcode address for profiling; forced break pending
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      last_fetch_ff <= 16'h0000;
      force_pend_ff <= 1'b0;
    end
    else
    begin
      if (cpu_valid && cpu_opfetch)
        last_fetch_ff <= cpu_addr; // RULE19
      // new request wins over the boundary that would clear it
      if ((sb_hit && sb_fts) || (brk && !tagsel && trigger))
        force_pend_ff <= 1'b1; // RULE2 RULE5 RULE13
      else if (insn_boundary)
        force_pend_ff <= 1'b0; // RULE2 RULE22
    end
  end
endmodule // debug_unit
`default_nettype wire

/* tb/debug_unit_assertions.sv */
// Purpose: watch break requests of debug_unit
// Assumes: fields shadowed from completed APB writes
// Notes:   shadow resets to zero like the enables it mirrors
`default_nettype none
module debug_unit_assertions (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        cpu_valid,
  input wire logic        cpu_opfetch,
  input wire logic [15:0] cpu_addr,
  input wire logic        bdc_access,
  input wire logic        insn_boundary,
  input wire logic        tag_break_req,
  input wire logic        force_break_req
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [15:0] sh_ff [0:5];
  // copy of written fields, the design's own copy is hidden
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      for (int k = 0; k < 6; k++)
        sh_ff[k] <= 16'h0000;
    else if (psel && penable && pwrite && paddr < 8'h18)
      sh_ff[paddr[4:2]] <= pwdata[15:0];
  // qualified hits; debugger cycles excluded
  wire en = sh_ff[0][7];
  wire force_tag_select = sh_ff[0][6];
  wire brk = sh_ff[4][6];
  logic run_ff;
  wire hit = cpu_valid && !bdc_access;
  wire sb = cpu_addr == sh_ff[1];
  wire dbga = run_ff && brk && !sh_ff[5][7] && sh_ff[5][3:0] == 4'h0
    && !sh_ff[4][3] && cpu_addr == sh_ff[2];
  // an end trace disarms at its first qualified A hit
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      run_ff <= 1'b0;
    else if (psel && penable && pwrite && paddr == 8'h10)
      run_ff <= pwdata[7];
    else if (hit && dbga)
      run_ff <= 1'b0;
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  property p_sb_force;
    hit && en && force_tag_select && sb |=> force_break_req;
  endproperty
  a_sb_force: assert property (p_sb_force)
    else $error("forced request missing");
  property p_hold;
    force_break_req && !insn_boundary |=> force_break_req;
  endproperty
  a_hold: assert property (p_hold)
    else $error("forced request dropped early");
  property p_clr;
    force_break_req && insn_boundary && !cpu_valid && !brk
      |=> !force_break_req;
  endproperty
  a_clr: assert property (p_clr)
    else $error("forced request kept past boundary");
  property p_sb_tag;
    hit && en && !force_tag_select && cpu_opfetch && sb |-> tag_break_req;
  endproperty
  a_sb_tag: assert property (p_sb_tag)
    else $error("tag missing on fetch");
  property p_off;
    !en && !brk && !force_break_req |-> !tag_break_req ##1 !force_break_req;
  endproperty
  a_off: assert property (p_off)
    else $error("request while disabled");
  property p_dbg_force;
    hit && dbga && !sh_ff[4][5] |-> ##[1:3] force_break_req;
  endproperty
  a_dbg_force: assert property (p_dbg_force)
    else $error("comparator break missing");
  property p_mute;
    cpu_valid && bdc_access && dbga && !en && !force_break_req
      && !$past(cpu_valid) |=> !force_break_req;
  endproperty
  a_mute: assert property (p_mute)
    else $error("debugger cycle matched");
  property p_dbg_tag;
    hit && dbga && sh_ff[4][5] && cpu_opfetch |-> tag_break_req;
  endproperty
  a_dbg_tag: assert property (p_dbg_tag)
    else $error("comparator tag missing");
endmodule // debug_unit_assertions
bind debug_unit debug_unit_assertions u_chk (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .cpu_valid(cpu_valid),
  .cpu_opfetch(cpu_opfetch), .cpu_addr(cpu_addr), .bdc_access(bdc_access),
  .insn_boundary(insn_boundary), .tag_break_req(tag_break_req),
  .force_break_req(force_break_req));
`default_nettype wire

/* tb/cpu_bus_model.sv */
// Purpose: CPU core side: bus cycles, execution, boundaries
// Assumes: every fetched opcode executes, queue never flushed
// Notes:   released lines invert so stale values never match
`default_nettype none
module cpu_bus_model (
  input  wire logic        pclk,
  input  wire logic        force_break_req,
  output var  logic        cpu_valid,
  output var  logic        cpu_rw,
  output var  logic        cpu_opfetch,
  output var  logic [15:0] cpu_addr,
  output var  logic [7:0]  cpu_rdata,
  output var  logic [7:0]  cpu_wdata,
  output var  logic        bdc_access,
  output var  logic        q_exec,
  output var  logic        insn_boundary,
  output var  logic        cof_valid,
  output var  logic [1:0]  cof_kind,
  output var  logic        cof_taken,
  output var  logic [15:0] cof_src,
  output var  logic [15:0] cof_dst
);
  timeunit 1ns;
  timeprecision 100ps;
  initial
  begin
    {cpu_valid, cpu_rw, cpu_opfetch, bdc_access} = 4'h0;
    {cpu_addr, cpu_rdata, cpu_wdata} = 32'h0000_0000;
    {q_exec, insn_boundary} = 2'h0;
    {cof_valid, cof_kind, cof_taken} = 4'h0;
    {cof_src, cof_dst} = 32'h0000_0000;
  end
  // one flow change, valid for a single cycle
  task automatic flow(input logic [1:0] k, input logic t,
                      input logic [15:0] s, input logic [15:0] d);
    @(posedge pclk);
    {cof_valid, cof_kind, cof_taken} <= {1'b1, k, t};
    cof_src <= s;
    cof_dst <= d;
    @(posedge pclk);
    cof_valid <= 1'b0;
  endtask
  // one read cycle, held until the next call
  task automatic cyc(input logic [15:0] a, input logic f,
                     input logic [7:0] d, input logic b);
    @(posedge pclk);
    {cpu_valid, cpu_rw, cpu_opfetch, bdc_access} <= {2'h3, f, b};
    cpu_addr <= a;
    cpu_rdata <= d;
    cpu_wdata <= ~d;
  endtask
  // bus released
  task automatic idle();
    @(posedge pclk);
    {cpu_valid, cpu_opfetch, bdc_access} <= 3'h0;
    cpu_rw <= ~cpu_rw;
    cpu_addr <= ~cpu_addr;
    cpu_rdata <= ~cpu_rdata;
    cpu_wdata <= ~cpu_wdata;
  endtask
  // fetch executes next cycle; force finishes the instruction first
  always @(posedge pclk)
  begin
    q_exec <= cpu_valid && cpu_opfetch;
    insn_boundary <= force_break_req && !insn_boundary;
  end
endmodule // cpu_bus_model
`default_nettype wire

/* tb/onchip_debug_breakpoint_trace_tb_top.sv */
// Purpose: self-checking bench of debug_unit
// Assumes: zero-wait APB slave, fields in low byte or low halfword
// Notes:   a queue models the capture FIFO
`default_nettype none
module onchip_debug_breakpoint_trace_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, err;
  logic [7:0] paddr = 8'h00, d;
  logic [1:0] k;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic [15:0] a, m, v;
  logic [15:0] q[$];
  wire pready, pslverr, cpu_valid, cpu_rw, cpu_opfetch, bdc_access;
  wire q_exec, insn_boundary, tag_break_req, force_break_req;
  wire cof_valid, cof_taken;
  wire [1:0] cof_kind;
  wire [15:0] cpu_addr, cof_src, cof_dst;
  wire [7:0] cpu_rdata, cpu_wdata;
  int n_errors = 0, checked = 0, cyc_n = 0;
  debug_unit DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cpu_valid(cpu_valid), .cpu_rw(cpu_rw), .cpu_opfetch(cpu_opfetch),
    .cpu_addr(cpu_addr), .cpu_rdata(cpu_rdata), .cpu_wdata(cpu_wdata),
    .bdc_access(bdc_access), .q_exec(q_exec), .q_flush(1'b0),
    .insn_boundary(insn_boundary), .cof_valid(cof_valid),
    .cof_kind(cof_kind), .cof_taken(cof_taken), .cof_src(cof_src),
    .cof_dst(cof_dst),
    .tag_break_req(tag_break_req), .force_break_req(force_break_req));
  cpu_bus_model cpu (.pclk(pclk), .force_break_req(force_break_req),
    .cpu_valid(cpu_valid), .cpu_rw(cpu_rw), .cpu_opfetch(cpu_opfetch),
    .cpu_addr(cpu_addr), .cpu_rdata(cpu_rdata), .cpu_wdata(cpu_wdata),
    .bdc_access(bdc_access), .q_exec(q_exec),
    .insn_boundary(insn_boundary), .cof_valid(cof_valid),
    .cof_kind(cof_kind), .cof_taken(cof_taken), .cof_src(cof_src),
    .cof_dst(cof_dst));
  always #2 pclk = ~pclk;
  task automatic test_done();
    if (n_errors == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  // one APB transfer; the wait ends only on pready or the timeout
  task automatic apb(input logic w, input logic [7:0] ad,
                     input logic [31:0] wd);
    @(posedge pclk);
    {psel, penable, pwrite} <= {2'h2, w};
    paddr <= ad;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'h0;
  endtask
  // hang guard, far above the run length
  always @(posedge pclk)
  begin
    cyc_n++;
    if (cyc_n > 5000)
    begin
      n_errors++;
      test_done();
    end
  end
  initial
  begin
    void'($urandom(32'h3a6d));
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, 8'h00, 0);
    chk(16'(rd[7]), 16'h0000);
    apb(0, 8'h24, 0);
    chk(16'({err, rd[7:0]}), 16'h0100);
    m = {4'h1, 12'($urandom())};
    apb(1, 8'h04, {16'h0000, m});
    apb(1, 8'h00, 32'h0000_0040);
    cpu.cyc(m, 1'b1, 8'h00, 1'b0);
    #1 chk(16'(tag_break_req), 16'h0000);
    apb(1, 8'h00, 32'h0000_00c0);
    cpu.cyc(m, 1'b0, 8'h00, 1'b0);
    cpu.idle();
    #1 chk(16'(force_break_req), 16'h0001);
    repeat (4) @(posedge pclk);
    #1 chk(16'(force_break_req), 16'h0000);
    apb(1, 8'h00, 32'h0000_0080);
    cpu.cyc(m, 1'b1, 8'h00, 1'b0);
    #1 chk(16'(tag_break_req), 16'h0001);
    cpu.idle();
    apb(1, 8'h00, 0);
    // comparator A breaks, debugger cycles muted
    a = {4'h4, 12'($urandom())};
    apb(1, 8'h08, {16'h0000, a});
    apb(1, 8'h14, 0);
    apb(1, 8'h10, 32'h0000_00c0);
    apb(0, 8'h18, 0);
    chk(16'({rd[5], rd[3:0]}), 16'h0010);
    cpu.cyc(a, 1'b0, 8'h00, 1'b1);
    cpu.idle();
    #1 chk(16'(force_break_req), 16'h0000);
    apb(0, 8'h18, 0);
    chk(16'(rd[7]), 16'h0000);
    cpu.cyc(a, 1'b0, 8'h00, 1'b0);
    cpu.idle();
    #1 chk(16'(force_break_req), 16'h0001);
    apb(0, 8'h18, 0);
    chk(16'(rd[7]), 16'h0001);
    apb(1, 8'h10, 32'h0000_00e0);
    cpu.cyc(a, 1'b1, 8'h00, 1'b0);
    #1 chk(16'(tag_break_req), 16'h0001);
    cpu.idle();
    // full mode on read data, or inside range; a hit forces a break
    repeat (4)
    begin
      d = 8'($urandom());
      v = {4'h6, 12'($urandom())};
      k = 2'($urandom());
      apb(1, 8'h08, {16'h0000, v});
      apb(1, 8'h0c, k[1] ? {16'h0000, v + 16'h0010} : {24'h0, d});
      apb(1, 8'h14, k[1] ? 32'h0000_0007 : 32'h0000_0003);
      apb(1, 8'h10, 32'h0000_00cc);
      cpu.cyc(v + {14'h0000, k[1], 1'b0}, 1'b0, k[0] ? ~d : d, 1'b0);
      cpu.idle();
      #1 chk(16'(force_break_req), 16'(k[1] || !k[0]));
      repeat (4) @(posedge pclk);
    end
    // event-only B: nine hits, only eight stored
    a = {4'h2, 12'($urandom())};
    apb(1, 8'h0c, {16'h0000, a});
    apb(1, 8'h14, 32'h0000_0005);
    apb(1, 8'h10, 32'h0000_0080);
    repeat (9)
    begin
      d = 8'($urandom());
      if (q.size() < 8)
        q.push_back(16'(d));
      cpu.cyc(a, 1'b0, d, 1'b0);
      cpu.idle();
    end
    apb(0, 8'h18, 0);
    chk(16'(rd[3:0]), 16'h0008);
    repeat (8)
    begin
      apb(0, 8'h1c, 0);
      chk(16'(rd[7:0]), 16'h0000);
      apb(0, 8'h20, 0);
      chk(16'(rd[7:0]), q.pop_front());
    end
    // profiling: first eight reads are stale
    apb(1, 8'h10, 0);
    repeat (16)
    begin
      v = {4'h8, 12'($urandom())};
      cpu.cyc(v, 1'b1, 8'h00, 1'b0);
      cpu.idle();
      apb(0, 8'h1c, 0);
      m = {rd[7:0], 8'h00};
      apb(0, 8'h20, 0);
      if (q.size() == 8)
        chk({m[15:8], rd[7:0]}, q.pop_front());
      q.push_back(v);
    end
    // end trace of flow changes, stopped by hand before full
    q.delete();
    apb(1, 8'h14, 0);
    apb(1, 8'h10, 32'h0000_0080);
    repeat (6)
    begin
      k = 2'($urandom());
      a = 16'($urandom());
      v = 16'($urandom());
      if (k >= 2'h2 || (k == 2'h0 && a[0]))
        q.push_back(k == 2'h0 ? a : v);
      cpu.flow(k, a[0], a, v);
    end
    apb(1, 8'h10, 0);
    apb(0, 8'h18, 0);
    chk(16'(rd[3:0]), 16'(q.size()));
    repeat (7 - q.size())
      apb(0, 8'h20, 0);
    while (q.size() > 0)
    begin
      apb(0, 8'h1c, 0);
      m = {rd[7:0], 8'h00};
      apb(0, 8'h20, 0);
      chk({m[15:8], rd[7:0]}, q.pop_front());
    end
    test_done();
  end
endmodule // onchip_debug_breakpoint_trace_tb_top
`default_nettype wire
